// ### ccso_chk.sv
// assertion checker for the clock and sysref output control block
`timescale 1ns/1ns
module ccso_chk
#(
	parameter NCLK = 10,
	parameter NREF = 8
)
(
	input wire              mclk,
	input wire              nrst,
	input wire              psel,
	input wire              penable,
	input wire [31:0]       prdata,
	input wire              pready,
	input wire              pslverr,
	input wire [NCLK-1:0]   clock_output,
	input wire [NCLK-1:0]   clock_output_n,
	input wire [NCLK-1:0]   clock_output_power_on,
	input wire [2*NCLK-1:0] clock_output_amp,
	input wire [NREF-1:0]   reference_output,
	input wire [NREF-1:0]   reference_output_n,
	input wire [NREF-1:0]   reference_output_xpt,
	input wire [NREF-1:0]   reference_output_power_on
);
	// one clock domain, reset disables every check
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	// pready is a single-cycle pulse
	property p_rdy_one; pready |=> !pready; endproperty
	a_rdy_one: assert property (p_rdy_one) else $error("pready longer than one cycle");
	// answer comes one cycle after the first access edge
	property p_one_wait; psel && penable && !pready |=> pready; endproperty
	a_one_wait: assert property (p_one_wait) else $error("apb answer late");
	// read data only moves with an answer
	property p_rd_hold; $changed(prdata) |-> pready; endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("prdata moved without pready");
	// reference outputs leave reset off, clock outputs with amplitude code 01
	property p_rst_idle;
		$rose(nrst) |-> clock_output_amp == {NCLK{2'b01}} && reference_output_power_on == 0;
	endproperty
	a_rst_idle: assert property (p_rst_idle) else $error("bad state after reset");
	// powered clock output 0 has complementary legs
	property p_clk_diff; clock_output_power_on[0] |-> clock_output[0] != clock_output_n[0]; endproperty
	a_clk_diff: assert property (p_clk_diff) else $error("clock legs not complementary");
	// crosspoint bias leaves both legs off
	property p_xpt_legs;
		|reference_output_xpt |-> ((reference_output | reference_output_n) & reference_output_xpt) == 0;
	endproperty
	a_xpt_legs: assert property (p_xpt_legs) else $error("legs driven at crosspoint");
	// crosspoint bias only on a powered-off stage
	property p_xpt_off; (reference_output_xpt & reference_output_power_on) == 0; endproperty
	a_xpt_off: assert property (p_xpt_off) else $error("crosspoint while powered");
	// powered reference output 0 without bias has complementary legs
	property p_ref_diff;
		reference_output_power_on[0] && !reference_output_xpt[0]
			|-> reference_output[0] != reference_output_n[0];
	endproperty
	a_ref_diff: assert property (p_ref_diff) else $error("reference legs equal");
	// main scenarios reached
	c_pulse: cover property ($rose(reference_output[0]));
	c_xpt: cover property ($rose(reference_output_xpt[0]));
	c_err: cover property (pslverr);
endmodule // ccso_chk

// ### ccso_conv_model.sv
// converter-side model counting sysref pulses on one reference lane
`timescale 1ns/1ns
module ccso_conv_model
(
	input  wire       mclk,
	input  wire       clr,
	input  wire       sr_p,
	input  wire       sr_n,
	output reg  [7:0] pulses
);
	reg prev_r; // last sampled true leg
	// counts rising edges of a driven lane; static levels add nothing
	always @(posedge mclk)
	begin
		prev_r <= sr_p;
		if (clr)
			pulses <= 8'h00;
		else if (sr_p && !prev_r && !sr_n)
			pulses <= pulses + 8'h01;
	end
endmodule // ccso_conv_model

// ### ccso_defines.vh
// constants for the clock and sysref output control block
`ifndef CCSO_DEFINES_VH
`define CCSO_DEFINES_VH
// register byte offsets
`define CCSO_OFS_CTRL     8'h00
`define CCSO_OFS_CHAN_PD  8'h04
`define CCSO_OFS_CLK_PD   8'h08
`define CCSO_OFS_CLK_EN   8'h0C
`define CCSO_OFS_REF_PD   8'h10
`define CCSO_OFS_REF_EN   8'h14
`define CCSO_OFS_REF_MODE 8'h18
`define CCSO_OFS_REF_BIAS 8'h1C
`define CCSO_OFS_CLK_AMP  8'h20
`define CCSO_OFS_REF_AMP  8'h24
`define CCSO_OFS_SR_CFG   8'h28
`define CCSO_OFS_SR_GDLY  8'h2C
`define CCSO_OFS_STATUS   8'h30
`define CCSO_OFS_CH_BASE  8'h40
`define CCSO_OFS_RF_BASE  8'h60
// control register bit positions
`define CCSO_CTRL_SYNC    0
`define CCSO_CTRL_REL     1
`define CCSO_CTRL_CONT    2
`define CCSO_CTRL_BTYPE   3
// reset values
`define CCSO_RST_DIV      8'h02
`define CCSO_RST_AMP      2'h1
`define CCSO_RST_SR_CNT   8'h01
`define CCSO_RST_SR_HALF  16'h0020
// amplitude codes
`define CCSO_AMP_250      2'h0
`define CCSO_AMP_500      2'h1
`define CCSO_AMP_750      2'h2
`define CCSO_AMP_1000     2'h3
// channel index of each clock output a0 a1 a2 b0 b1 c0 c1 d e0 e1 (lsb first)
`define CCSO_CLK_CH_MAP   30'h24691200
// channel index of each reference output a0 a1 a2 b0 b1 c0 c1 d
`define CCSO_REF_CH_MAP   24'h691200
// delay step times in ps and tap counts
`define CCSO_VCO_STEP_PS  339
`define CCSO_CRS_STEP_PS  169
`define CCSO_CRS_TAPS     8
`define CCSO_MIN_DIV      8'h02
`endif

// ### ccso_outcell.v
// one differential output stage: clock or sysref mode, power, enable, bias
`timescale 1ns/1ns
`include "ccso_defines.vh"
module ccso_outcell
(
	input  wire       mclk,
	input  wire       rst_n,
	input  wire       pd,
	input  wire       en,
	input  wire [1:0] amp,
	input  wire       mode,
	input  wire       bias_ctrl,
	input  wire       bias_type,
	input  wire       clk_in,
	input  wire       sr_in,
	input  wire       sr_act,
	output reg        q_r,
	output reg        qn_r,
	output reg        xpt_r,
	output reg        pwr_r,
	output reg  [1:0] amp_r
);
	// output state register
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			q_r   <= 1'b0;
			qn_r  <= 1'b0;
			xpt_r <= 1'b0;
			pwr_r <= 1'b0;
			amp_r <= `CCSO_AMP_500;
		end
		else if (pd)
		begin
			// powered off whatever else is set
			q_r   <= 1'b0;
			qn_r  <= 1'b0;
			xpt_r <= 1'b0;
			pwr_r <= 1'b0;
			amp_r <= amp;
		end
		else if (!mode)
		begin
			// clock mode: individual settings govern
			pwr_r <= 1'b1;
			xpt_r <= 1'b0;
			q_r   <= en & clk_in; // disabled holds low
			qn_r  <= ~(en & clk_in);
			amp_r <= amp; // amplitude code passed to the driver
		end
		else if (bias_ctrl)
		begin
			// line bias: off, both legs at crosspoint
			pwr_r <= 1'b0;
			xpt_r <= 1'b1;
			q_r   <= 1'b0;
			qn_r  <= 1'b0;
			amp_r <= amp;
		end
		else if (sr_act)
		begin
			// event running: output switched on
			pwr_r <= 1'b1;
			xpt_r <= 1'b0;
			q_r   <= en & sr_in;
			qn_r  <= ~(en & sr_in);
			amp_r <= amp;
		end
		else
		begin
			// idle: static low or crosspoint
			pwr_r <= ~bias_type;
			xpt_r <= bias_type;
			q_r   <= 1'b0;
			qn_r  <= ~bias_type;
			amp_r <= amp;
		end
	end
endmodule // ccso_outcell

// ### ccso_top.v
// clock and sysref output control: apb registers, channel clocks, sysref sequencer
`timescale 1ns/1ns
`include "ccso_defines.vh"
// Behaviour
// - power-off bit forces output off regardless; reference power-off only in clock mode
// - enable per output; disabled holds static low
// - two-bit amplitude code selects 250..1000 mV
// - clock settings apply only in clock mode
// - sequencer switches sysref outputs on and off with bias type 1
// - line bias puts both legs at crosspoint in sysref mode
// - bias type 0 rests static low
// - bias type 1 rests at crosspoint
// - each event gives exactly the programmed pulses
// - clock and sysref delays are independent
// - channel delay 256 vco steps, edges aligned
// - sysref coarse delay of 8 steps
// - sysref fine delay of eight settings
// - global sysref delay of 256 steps
// - half-period clock delay inverts the output
// - mode select chooses clock copy or sysref
module ccso_top
#(
	parameter NCH  = 5,
	parameter NCLK = 10,
	parameter NREF = 8
)
(
	input  wire              mclk,
	input  wire              nrst,
	input  wire              psel,
	input  wire              penable,
	input  wire              pwrite,
	input  wire [7:0]        paddr,
	input  wire [31:0]       pwdata,
	output reg  [31:0]       prdata,
	output reg               pready,
	output reg               pslverr,
	output wire [NCLK-1:0]   clock_output,
	output wire [NCLK-1:0]   clock_output_n,
	output wire [NCLK-1:0]   clock_output_power_on,
	output wire [2*NCLK-1:0] clock_output_amp,
	output wire [NREF-1:0]   reference_output,
	output wire [NREF-1:0]   reference_output_n,
	output wire [NREF-1:0]   reference_output_xpt,
	output wire [NREF-1:0]   reference_output_power_on,
	output wire [2*NREF-1:0] reference_output_amp,
	output reg  [3*NREF-1:0] ref_fine_sel
);
	// reset synchroniser
	reg              rst_s1_r;  // first stage
	reg              rst_n;     // released reset copy
	// registers
	reg [NCH-1:0]    chan_pd_r;  // output_power_off per channel
	reg [NCLK-1:0]   clk_pd_r;   // output_power_off per clock output
	reg [NCLK-1:0]   clk_en_r;   // clock output enable
	reg [NREF-1:0]   ref_pd_r;   // reference power-off in clock mode
	reg [NREF-1:0]   ref_en_r;   // reference output enable
	reg [NREF-1:0]   ref_mode_r; // ref_output_mode: 0 clock, 1 sysref
	reg [NREF-1:0]   bias_r;     // line_bias_ctrl per reference
	reg [2*NCLK-1:0] clk_amp_r;  // clock amplitude codes
	reg [2*NREF-1:0] ref_amp_r;  // reference amplitude codes
	reg [8*NCH-1:0]  div_r;      // channel divider
	reg [8*NCH-1:0]  pha_r;      // channel phase delay in vco steps
	reg [3*NREF-1:0] crs_r;      // sysref coarse delay
	reg [7:0]        sr_cnt_r;   // pulses per event
	reg [15:0]       sr_half_r;  // sysref half period in vco steps
	reg [7:0]        gdly_r;     // global sysref delay
	reg              cont_r;     // continuous sysref
	reg              btype_r;    // bias type
	reg              sync_r;     // one-cycle divider restart
	reg              rel_r;      // one-cycle sysref release
	// sysref sequencer
	localparam SQ_IDLE = 3'b001;
	localparam SQ_WAIT = 3'b010;
	localparam SQ_RUN  = 3'b100;
	reg [2:0]        sq_r;
	reg [2:0]        sq_nxt;
	reg [7:0]        gcnt_r;     // global delay count
	reg [15:0]       hcnt_r;     // half period count
	reg [7:0]        left_r;     // pulses still to send
	reg              sr_r;       // sysref level
	reg [`CCSO_CRS_TAPS-1:0] sr_sh_r;  // coarse tap line, level
	reg [`CCSO_CRS_TAPS-1:0] act_sh_r; // coarse tap line, active window
	// channel clocks
	wire [NCH-1:0]   ch_clk;
	reg  [31:0]      rd_nxt;
	reg              hit_nxt;
	wire             acc;
	localparam [7:0]  CH_BASE = `CCSO_OFS_CH_BASE; // channel delay window base
	localparam [7:0]  RF_BASE = `CCSO_OFS_RF_BASE; // reference delay window base
	localparam [29:0] CLK_MAP = `CCSO_CLK_CH_MAP;  // clock output to channel index
	localparam [23:0] REF_MAP = `CCSO_REF_CH_MAP;  // reference output to channel index

	// reset released through two flops
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			rst_s1_r <= 1'b0;
			rst_n    <= 1'b0;
		end
		else
		begin
			rst_s1_r <= 1'b1;
			rst_n    <= rst_s1_r;
		end
	end

	// access phase, answered one cycle after it starts
	assign acc = psel & penable & ~pready;

	// read mux and address decode
	always @*
	begin
		rd_nxt  = 32'h00000000;
		hit_nxt = 1'b1;
		case (paddr)
			`CCSO_OFS_CTRL:     rd_nxt = {28'h0000000, btype_r, cont_r, 2'h0};
			`CCSO_OFS_CHAN_PD:  rd_nxt[NCH-1:0] = chan_pd_r;
			`CCSO_OFS_CLK_PD:   rd_nxt[NCLK-1:0] = clk_pd_r;
			`CCSO_OFS_CLK_EN:   rd_nxt[NCLK-1:0] = clk_en_r;
			`CCSO_OFS_REF_PD:   rd_nxt[NREF-1:0] = ref_pd_r;
			`CCSO_OFS_REF_EN:   rd_nxt[NREF-1:0] = ref_en_r;
			`CCSO_OFS_REF_MODE: rd_nxt[NREF-1:0] = ref_mode_r;
			`CCSO_OFS_REF_BIAS: rd_nxt[NREF-1:0] = bias_r;
			`CCSO_OFS_CLK_AMP:  rd_nxt[2*NCLK-1:0] = clk_amp_r;
			`CCSO_OFS_REF_AMP:  rd_nxt[2*NREF-1:0] = ref_amp_r;
			`CCSO_OFS_SR_CFG:   rd_nxt = {8'h00, sr_half_r, sr_cnt_r};
			`CCSO_OFS_SR_GDLY:  rd_nxt = {24'h000000, gdly_r};
			`CCSO_OFS_STATUS:   rd_nxt = {21'h000000, sq_r, left_r};
			default:
			begin
				// channel and reference delay windows
				if (paddr[7:5] == CH_BASE[7:5] && {29'h0000000, paddr[4:2]} < NCH
					&& paddr[1:0] == 2'h0)
				begin
					rd_nxt[7:0]  = div_r[8*paddr[4:2] +: 8];
					rd_nxt[15:8] = pha_r[8*paddr[4:2] +: 8];
				end
				else if (paddr[7:5] == RF_BASE[7:5] && paddr[1:0] == 2'h0)
				begin
					rd_nxt[2:0] = crs_r[3*paddr[4:2] +: 3];
					rd_nxt[6:4] = ref_fine_sel[3*paddr[4:2] +: 3];
				end
				else
					hit_nxt = 1'b0;
			end
		endcase
	end

	// apb slave and register writes
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			prdata       <= 32'h00000000;
			pready       <= 1'b0;
			pslverr      <= 1'b0;
			chan_pd_r    <= {NCH{1'b0}};
			clk_pd_r     <= {NCLK{1'b0}};
			clk_en_r     <= {NCLK{1'b0}};
			ref_pd_r     <= {NREF{1'b0}};
			ref_en_r     <= {NREF{1'b0}};
			ref_mode_r   <= {NREF{1'b0}};
			bias_r       <= {NREF{1'b0}};
			clk_amp_r    <= {NCLK{`CCSO_RST_AMP}};
			ref_amp_r    <= {NREF{`CCSO_RST_AMP}};
			div_r        <= {NCH{`CCSO_RST_DIV}};
			pha_r        <= {8*NCH{1'b0}};
			crs_r        <= {3*NREF{1'b0}};
			ref_fine_sel <= {3*NREF{1'b0}};
			sr_cnt_r     <= `CCSO_RST_SR_CNT;
			sr_half_r    <= `CCSO_RST_SR_HALF;
			gdly_r       <= 8'h00;
			cont_r       <= 1'b0;
			btype_r      <= 1'b0;
			sync_r       <= 1'b0;
			rel_r        <= 1'b0;
		end
		else
		begin
			pready  <= acc;
			pslverr <= acc & ~hit_nxt;
			sync_r  <= 1'b0;
			rel_r   <= 1'b0;
			if (acc && !pwrite)
				prdata <= rd_nxt;
			if (acc && pwrite && hit_nxt)
			begin
				case (paddr)
					`CCSO_OFS_CTRL:
					begin
						sync_r  <= pwdata[`CCSO_CTRL_SYNC];
						rel_r   <= pwdata[`CCSO_CTRL_REL];
						cont_r  <= pwdata[`CCSO_CTRL_CONT];
						btype_r <= pwdata[`CCSO_CTRL_BTYPE];
					end
					`CCSO_OFS_CHAN_PD:  chan_pd_r  <= pwdata[NCH-1:0];
					`CCSO_OFS_CLK_PD:   clk_pd_r   <= pwdata[NCLK-1:0];
					`CCSO_OFS_CLK_EN:   clk_en_r   <= pwdata[NCLK-1:0];
					`CCSO_OFS_REF_PD:   ref_pd_r   <= pwdata[NREF-1:0];
					`CCSO_OFS_REF_EN:   ref_en_r   <= pwdata[NREF-1:0];
					`CCSO_OFS_REF_MODE: ref_mode_r <= pwdata[NREF-1:0];
					`CCSO_OFS_REF_BIAS: bias_r     <= pwdata[NREF-1:0];
					`CCSO_OFS_CLK_AMP:  clk_amp_r  <= pwdata[2*NCLK-1:0];
					`CCSO_OFS_REF_AMP:  ref_amp_r  <= pwdata[2*NREF-1:0];
					`CCSO_OFS_SR_CFG:
					begin
						sr_cnt_r  <= pwdata[7:0];
						sr_half_r <= pwdata[23:8];
					end
					`CCSO_OFS_SR_GDLY:  gdly_r <= pwdata[7:0];
					`CCSO_OFS_STATUS:   ;
					default:
					begin
						// delay windows; clock and sysref delays kept apart
						if (paddr[7:5] == CH_BASE[7:5])
						begin
							div_r[8*paddr[4:2] +: 8] <= pwdata[7:0];
							pha_r[8*paddr[4:2] +: 8] <= pwdata[15:8];
						end
						else
						begin
							crs_r[3*paddr[4:2] +: 3]        <= pwdata[2:0];
							ref_fine_sel[3*paddr[4:2] +: 3] <= pwdata[6:4];
						end
					end
				endcase
			end
		end
	end

	// channel dividers, all restarted together by sync so rising edges align
	genvar c;
	generate
		for (c = 0; c < NCH; c = c + 1)
		begin : g_ch
			reg [7:0] dly_r;  // phase delay still to wait
			reg [7:0] ph_r;   // position within the output period
			reg       run_r;  // divider running
			reg       lvl_r;  // channel clock level
			wire [7:0] dv;
			assign dv = (div_r[8*c +: 8] < `CCSO_MIN_DIV) ? `CCSO_MIN_DIV
				: div_r[8*c +: 8];
			// delayed start then divide; delay of dv/2 gives inversion
			always @(posedge mclk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					dly_r <= 8'h00;
					ph_r  <= 8'h00;
					run_r <= 1'b0;
					lvl_r <= 1'b0;
				end
				else if (sync_r)
				begin
					dly_r <= pha_r[8*c +: 8]; // one vco step per cycle
					ph_r  <= 8'h00;
					run_r <= 1'b0;
					lvl_r <= 1'b0;
				end
				else if (dly_r != 8'h00)
					dly_r <= dly_r - 8'h01;
				else
				begin
					// high for the first half period
					run_r <= 1'b1;
					lvl_r <= (ph_r < {1'b0, dv[7:1]});
					ph_r  <= (ph_r >= dv - 8'h01) ? 8'h00 : ph_r + 8'h01;
				end
			end
			assign ch_clk[c] = lvl_r & run_r;
		end
	endgenerate

	// sysref sequencer next state
	always @*
	begin
		sq_nxt = sq_r;
		case (sq_r)
			SQ_IDLE: if (rel_r) sq_nxt = SQ_WAIT;
			SQ_WAIT: if (gcnt_r == 8'h00) sq_nxt = SQ_RUN;
			SQ_RUN:
			begin
				// stop after the last counted pulse; never while continuous is set
				if (cont_r ? 1'b0 : (left_r == 8'h00))
					sq_nxt = SQ_IDLE;
				else if (!cont_r && left_r == 8'h00)
					sq_nxt = SQ_IDLE;
			end
			default: sq_nxt = SQ_IDLE;
		endcase
		if (sq_r == SQ_RUN && cont_r == 1'b0 && left_r == 8'h00)
			sq_nxt = SQ_IDLE;
	end

	// sysref pulse generator
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sq_r   <= SQ_IDLE; // idle with no pulses
			gcnt_r <= 8'h00;
			hcnt_r <= 16'h0000;
			left_r <= 8'h00;
			sr_r   <= 1'b0;
		end
		else
		begin
			sq_r <= sq_nxt;
			case (sq_r)
				SQ_IDLE:
				begin
					sr_r   <= 1'b0;
					gcnt_r <= gdly_r;   // global shift for every output
					left_r <= sr_cnt_r; // pulse count taken at release
					hcnt_r <= 16'h0000;
				end
				SQ_WAIT:
				begin
					if (gcnt_r != 8'h00)
						gcnt_r <= gcnt_r - 8'h01;
				end
				SQ_RUN:
				begin
					// each high-then-low period is one pulse
					if (hcnt_r != 16'h0000)
						hcnt_r <= hcnt_r - 16'h0001;
					else if (!sr_r && (cont_r || left_r != 8'h00))
					begin
						sr_r   <= 1'b1;
						hcnt_r <= sr_half_r - 16'h0001;
					end
					else if (sr_r)
					begin
						sr_r   <= 1'b0;
						hcnt_r <= sr_half_r - 16'h0001;
						if (!cont_r)
							left_r <= left_r - 8'h01;
					end
				end
				default: sr_r <= 1'b0;
			endcase
		end
	end

	// coarse delay taps for level and active window
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sr_sh_r  <= {`CCSO_CRS_TAPS{1'b0}};
			act_sh_r <= {`CCSO_CRS_TAPS{1'b0}};
		end
		else
		begin
			sr_sh_r  <= {sr_sh_r[`CCSO_CRS_TAPS-2:0], sr_r};
			act_sh_r <= {act_sh_r[`CCSO_CRS_TAPS-2:0], sq_r == SQ_RUN};
		end
	end

	// clock output stages
	genvar k;
	generate
		for (k = 0; k < NCLK; k = k + 1)
		begin : g_clk
			wire [2:0] ch;
			assign ch = CLK_MAP[3*k +: 3];
			ccso_outcell u_cell
			(
				.mclk      (mclk),
				.rst_n     (rst_n),
				.pd        (clk_pd_r[k] | chan_pd_r[ch]),
				.en        (clk_en_r[k]),
				.amp       (clk_amp_r[2*k +: 2]),
				.mode      (1'b0),
				.bias_ctrl (1'b0),
				.bias_type (1'b0),
				.clk_in    (ch_clk[ch]),
				.sr_in     (1'b0),
				.sr_act    (1'b0),
				.q_r       (clock_output[k]),
				.qn_r      (clock_output_n[k]),
				.xpt_r     (),
				.pwr_r     (clock_output_power_on[k]),
				.amp_r     (clock_output_amp[2*k +: 2])
			);
		end
		// reference output stages
		for (k = 0; k < NREF; k = k + 1)
		begin : g_ref
			wire [2:0] ch;
			wire [2:0] tap;
			assign ch  = REF_MAP[3*k +: 3];
			assign tap = crs_r[3*k +: 3];
			ccso_outcell u_cell
			(
				.mclk      (mclk),
				.rst_n     (rst_n),
				.pd        (chan_pd_r[ch] | (~ref_mode_r[k] & ref_pd_r[k])),
				.en        (ref_en_r[k]),
				.amp       (ref_amp_r[2*k +: 2]),
				.mode      (ref_mode_r[k]),
				.bias_ctrl (bias_r[k]),
				.bias_type (btype_r),
				.clk_in    (ch_clk[ch]),
				.sr_in     (sr_sh_r[tap]),
				.sr_act    (act_sh_r[tap]),
				.q_r       (reference_output[k]),
				.qn_r      (reference_output_n[k]),
				.xpt_r     (reference_output_xpt[k]),
				.pwr_r     (reference_output_power_on[k]),
				.amp_r     (reference_output_amp[2*k +: 2])
			);
		end
	endgenerate
endmodule // ccso_top

// ### clock_sysref_output_control_tb_top.sv
// self-checking bench for the clock and sysref output control block
`timescale 1ns/1ns
`include "ccso_defines.vh"
module clock_sysref_output_control_tb_top;
	reg         mclk = 1'b0;     // 50 MHz clock
	reg         nrst = 1'b0;     // active-low reset
	reg         psel = 1'b0;
	reg         penable = 1'b0;
	reg         pwrite = 1'b0;
	reg  [7:0]  paddr = 8'h00;
	reg  [31:0] pwdata = 32'h0;
	reg         clr = 1'b1;      // clears the pulse counter
	wire [31:0] prdata;
	wire        pready;
	wire        pslverr;
	wire [9:0]  clock_output, clock_output_n, clock_output_power_on;
	wire [19:0] clock_output_amp;
	wire [7:0]  reference_output, reference_output_n, reference_output_xpt;
	wire [7:0]  reference_output_power_on;
	wire [15:0] reference_output_amp;
	wire [23:0] ref_fine_sel;    // fine delay codes per reference
	reg  [7:0]  ra;              // reference delay window address
	wire [7:0]  pulses;          // pulses seen by the converter
	integer     bad_count = 0;   // mismatches
	integer     num_checks = 0;  // comparisons made
	integer     n, m, k;
	reg  [31:0] q, e;
	reg         err;
	always #10 mclk = ~mclk;
	ccso_top DUT (.mclk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .clock_output, .clock_output_n, .clock_output_power_on, .clock_output_amp,
		.reference_output, .reference_output_n, .reference_output_xpt,
		.reference_output_power_on, .reference_output_amp, .ref_fine_sel);
	ccso_conv_model conv (.mclk, .clr, .sr_p(reference_output[0]),
		.sr_n(reference_output_n[0]), .pulses);
	// count one comparison, report a mismatch
	task chk(input [31:0] got, input [31:0] exp);
	begin
		num_checks = num_checks + 1;
		if (got !== exp)
		begin
			bad_count = bad_count + 1;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	end
	endtask
	// counts, verdict, end of run
	task give_verdict;
	begin
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	end
	endtask
	// one apb transfer, held until pready is seen at an edge
	task apb(input w, input [7:0] a, input [31:0] d);
	begin
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge mclk);
			n = n + 1;
		end
		while (pready !== 1'b1 && n < 20);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
		begin
			bad_count = bad_count + 1;
			$display("[ERR] %0t bus timeout", $time);
			give_verdict;
		end
	end
	endtask
	// idle legs of a sysref lane as {true, complement, crosspoint}
	function [2:0] idle_of(input b);
		idle_of = b ? 3'b001 : 3'b010;
	endfunction
	// main sequence
	initial
	begin
		k = $urandom(32'h29005017);
		repeat (12) @(posedge mclk);
		nrst <= 1'b1;
		repeat (5) @(posedge mclk);
		chk(clock_output_amp, 32'h55555);
		chk(reference_output_n, 32'hFF);
		apb(0, `CCSO_OFS_SR_CFG, 32'h0);
		chk(q, 32'h2001);
		apb(0, 8'hFC, 32'h0);
		chk(err, 32'h1);
		$display("test reset and registers done");
		apb(1, `CCSO_OFS_CLK_EN, 32'h3FF);
		// every amplitude code on every clock output
		for (k = 0; k < 4; k = k + 1)
		begin
			e = {10{k[1:0]}};
			apb(1, `CCSO_OFS_CLK_AMP, e);
			for (m = 0; m < 8 && clock_output_amp !== e[19:0]; m = m + 1) @(posedge mclk);
			chk(clock_output_amp, e);
		end
		// random per-output power-off, then channel a off
		e = $urandom & 32'h3FF;
		apb(1, 8'h08, e);
		for (m = 0; m < 8 && clock_output_power_on !== ~e[9:0]; m = m + 1) @(posedge mclk);
		chk(clock_output_power_on, ~e & 32'h3FF);
		apb(1, 8'h08, 32'h0);
		apb(1, 8'h04, 32'h1);
		for (m = 0; m < 8 && clock_output_power_on[2:0] !== 3'h0; m = m + 1) @(posedge mclk);
		chk({clock_output_power_on[2:0], reference_output_power_on[2:0]}, 32'h0);
		apb(1, 8'h04, 32'h0);
		$display("test amplitude and power done");
		// channel b delayed half a period against channel a
		apb(1, `CCSO_OFS_CH_BASE, 32'h4);
		apb(1, 8'h44, 32'h204);
		apb(1, `CCSO_OFS_CTRL, 32'h1);
		repeat (12) @(posedge mclk);
		for (k = 0; k < 8; k = k + 1)
		begin
			@(posedge mclk);
			chk(clock_output[3], {31'h0, ~clock_output[0]});
		end
		apb(1, `CCSO_OFS_CLK_EN, 32'h0);
		for (m = 0; m < 8 && clock_output !== 10'h0; m = m + 1) @(posedge mclk);
		for (k = 0; k < 8; k = k + 1)
		begin
			@(posedge mclk);
			chk(clock_output, 32'h0);
		end
		$display("test clock delay and enable done");
		// counted sysref events for both bias types
		apb(1, `CCSO_OFS_REF_EN, 32'hFF);
		apb(1, `CCSO_OFS_REF_AMP, 32'h5555);
		apb(1, `CCSO_OFS_REF_MODE, 32'hFF);
		chk(reference_output_amp, 32'h5555);
		// random coarse and fine delay on a random reference, global delay
		k = $urandom % 8;
		ra = `CCSO_OFS_RF_BASE | {k[2:0], 2'h0};
		e = $urandom & 32'h77;
		apb(1, ra, e);
		chk(ref_fine_sel[3*k +: 3], e[6:4]);
		apb(0, ra, 32'h0);
		chk(q, e);
		apb(1, `CCSO_OFS_SR_GDLY, $urandom % 8);
		for (k = 0; k < 2; k = k + 1)
		begin
			e = 1 + $urandom % 5;
			apb(1, `CCSO_OFS_CTRL, k << 3);
			apb(1, `CCSO_OFS_SR_CFG, 32'h200 | e);
			chk({reference_output[0], reference_output_n[0], reference_output_xpt[0]},
				idle_of(k));
			clr <= 1'b0;
			apb(1, `CCSO_OFS_CTRL, (k << 3) | 2);
			m = 0;
			do
			begin
				apb(0, `CCSO_OFS_STATUS, 32'h0);
				m = m + 1;
			end
			while (q[10:8] !== 3'b001 && m < 40);
			if (q[10:8] !== 3'b001)
			begin
				bad_count = bad_count + 1;
				$display("[ERR] %0t sysref event did not end", $time);
				give_verdict;
			end
			// let the last pulse pass the coarse taps
			repeat (12) @(posedge mclk);
			chk(pulses, e);
			chk({reference_output[0], reference_output_n[0], reference_output_xpt[0]},
				idle_of(k));
			clr <= 1'b1;
		end
		$display("test sysref events done");
		// line bias on lane 0
		apb(1, `CCSO_OFS_REF_BIAS, 32'h1);
		for (m = 0; m < 8 && reference_output_xpt[0] !== 1'b1; m = m + 1) @(posedge mclk);
		chk({reference_output_xpt[0], reference_output_power_on[0]}, 32'h2);
		$display("test line bias done");
		give_verdict;
	end
endmodule // clock_sysref_output_control_tb_top
bind ccso_top ccso_chk #(.NCLK(NCLK), .NREF(NREF)) u_chk (.mclk, .nrst, .psel, .penable,
	.prdata, .pready, .pslverr, .clock_output, .clock_output_n, .clock_output_power_on,
	.clock_output_amp, .reference_output, .reference_output_n, .reference_output_xpt,
	.reference_output_power_on);
